/* File: verilog/cecr_rx.sv */
// cecr_rx: receive bit engine of a single-wire open-drain control link.
// Assumes an external pull-up on the line and a reader draining the ring buffer.
// Operation
// - a start bit's falling edge arms a 6.0 ms timeout that ends in error handling if no edge follows.
// - the timer is saved at the start bit's rise as period A and at the next fall as period B and both are checked.
// - a start period A or B outside its window sets the start-bit timing error.
// - each data bit's fall arms 1.05 ms, at whose end a high line is a one and a low line a zero.
// - after sampling, a 3.6 ms timer bounds the wait for the edge ending the bit.
// - a data bit's low period A outside its windows sets the data-bit timing error.
// - a data period B below the minimum sets the handling error and drives the line low.
// - a data period B otherwise out of window sets the data-bit timing error.
// - when acknowledging, the line is pulled low from the ack fall for 1.05 ms, then released.
// - when not acknowledging, nothing is driven and only the 1.05 ms timer runs.
// - after the ack timer, if the frame goes on, 1.5 ms is armed while awaiting the next fall.
// - after the last ack, the signal-free time is timed before the line counts as idle.
// - received bytes go in order into a ring buffer with separate read and write pointers.
`timescale 1ns/100ps
`default_nettype none
module cecr_rx
#(
	// clocks per 10 us tick; only a bench should change it
	parameter int TICK_CYC = cecr_pkg::TICK_CYC
)
(
	// clock and reset
	input  wire logic MCLK_I,
	input  wire logic RESETN_I,
	// open-drain line
	input  wire logic CEC_LINE_I,
	output logic      CEC_LINE_O,
	output logic      CEC_LINE_OE_O,
	// control
	input  wire logic ACK_EN_I,
	input  wire logic ERR_CLR_I,
	// ring buffer read side
	input  wire logic RB_RD_I,
	output logic [7:0] RB_DATA_O,
	output logic      RB_EOM_O,
	output logic      RB_NONEMPTY_O,
	// status
	output logic      LINE_IDLE_O,
	output logic      START_BIT_TIMING_ERROR_O,
	output logic      DATA_BIT_TIMING_ERROR_O,
	output logic      RECEIVE_HANDLING_ERROR_O,
	output logic      RB_OVERFLOW_O
);
	localparam int T_W = cecr_pkg::T_W;
	localparam int AW  = cecr_pkg::RB_AW;

	typedef struct packed {
		cecr_pkg::cecr_state_t                               state;
		logic [T_W-1:0]                                      tmr;
		logic [T_W-1:0]                                      elapsed;
		logic [3:0]                                          bit_cnt;
		logic [7:0]                                          shreg;
		logic                                                eom;
		logic                                                oe;
		logic                                                idle;
		cecr_pkg::cecr_entry_t [cecr_pkg::RB_DEPTH-1:0]      mem;
		logic [AW:0]                                         wr_ptr;
		logic [AW:0]                                         rd_ptr;
		cecr_pkg::cecr_entry_t                               rd_data;
		logic                                                nonempty;
		cecr_pkg::cecr_err_t                                 err;
	} cecr_rx_t;

	cecr_rx_t   s_reg;
	cecr_rx_t   s_next;
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	logic       line;
	logic       fall;
	logic       rise;
	logic       tick;

	// window test used by the start periods and the data low period; data period B is compared directly
	function automatic logic in_win(input logic [T_W-1:0] v, input logic [T_W-1:0] lo, input logic [T_W-1:0] hi);
		in_win = (v >= lo) && (v <= hi);
	endfunction

	// ==========================================
	// reset release through two flops
	always_ff @(posedge MCLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// ==========================================
	// synchronised line, edges and tick
	cecr_timebase
	#(
		.TICK_CYC (TICK_CYC)
	)
	u_timebase
	(
		.clk_i   (MCLK_I),
		.rst_n_i (rst_n),
		.line_i  (CEC_LINE_I),
		.line_o  (line),
		.fall_o  (fall),
		.rise_o  (rise),
		.tick_o  (tick)
	);

	// ==========================================
	// bit engine, ring buffer and status
	always_comb
	begin
		logic tmr_hit;
		logic [AW:0] wr_nx;
		tmr_hit = 1'b0;
		wr_nx   = '0;
		s_next  = s_reg;
		// elapsed ticks since the last counted fall, saturating
		if (tick && (s_reg.elapsed != {T_W{1'b1}}))
			s_next.elapsed = s_reg.elapsed + T_W'(1);
		// one-shot timer, expires on the tick that takes it to zero
		if (tick && (s_reg.tmr != '0))
		begin
			s_next.tmr = s_reg.tmr - T_W'(1);
			tmr_hit    = (s_reg.tmr == T_W'(1));
		end
		// software clear first, so a same-cycle set wins
		if (ERR_CLR_I)
			s_next.err = '0;

		case (s_reg.state)
			cecr_pkg::ST_IDLE, cecr_pkg::ST_SFT:
			begin
				// a fall ends the free time at once; frames are never missed
				if (fall)
				begin
					s_next.state   = cecr_pkg::ST_START_LOW;
					s_next.tmr     = cecr_pkg::START_TO;
					s_next.elapsed = '0;
				end
				else if ((s_reg.state == cecr_pkg::ST_SFT) && tmr_hit)
					s_next.state = cecr_pkg::ST_IDLE;
			end
			cecr_pkg::ST_START_LOW, cecr_pkg::ST_START_HIGH:
			begin
				if (rise && (s_reg.state == cecr_pkg::ST_START_LOW))
				begin
					s_next.state = cecr_pkg::ST_START_HIGH;
					s_next.tmr   = cecr_pkg::START_TO;
					if (!in_win(s_reg.elapsed, cecr_pkg::ST_A_MIN, cecr_pkg::ST_A_MAX))
					begin
						s_next.err.start_tm = 1'b1;
						s_next.state        = cecr_pkg::ST_IDLE;
						s_next.tmr          = '0;
					end
				end
				else if (fall && (s_reg.state == cecr_pkg::ST_START_HIGH))
				begin
					s_next.elapsed = '0;
					if (!in_win(s_reg.elapsed, cecr_pkg::ST_B_MIN, cecr_pkg::ST_B_MAX))
					begin
						s_next.err.start_tm = 1'b1;
						s_next.state        = cecr_pkg::ST_START_LOW;
						s_next.tmr          = cecr_pkg::START_TO;
					end
					else
					begin
						s_next.state   = cecr_pkg::ST_BIT_SAMPLE;
						s_next.tmr     = cecr_pkg::SAMPLE_T;
						s_next.bit_cnt = '0;
					end
				end
				else if (tmr_hit)
				begin
					s_next.err.handling = 1'b1;
					s_next.state        = cecr_pkg::ST_IDLE;
				end
			end
			cecr_pkg::ST_BIT_SAMPLE, cecr_pkg::ST_BIT_WAIT:
			begin
				if (rise)
				begin
					if (!in_win(s_reg.elapsed, cecr_pkg::ONE_MIN, cecr_pkg::ONE_MAX) &&
						!in_win(s_reg.elapsed, cecr_pkg::ZERO_MIN, cecr_pkg::ZERO_MAX))
						s_next.err.data_tm = 1'b1;
				end
				if (fall && ((s_reg.state == cecr_pkg::ST_BIT_SAMPLE) || (s_reg.elapsed < cecr_pkg::BIT_B_MIN)))
				begin
					// too short, notify by pulling low
					s_next.err.handling = 1'b1;
					s_next.state        = cecr_pkg::ST_ERR_LOW;
					s_next.tmr          = cecr_pkg::ERR_LOW_T;
					s_next.oe           = 1'b1;
				end
				else if (fall)
				begin
					if (s_reg.elapsed > cecr_pkg::BIT_B_MAX)
						s_next.err.data_tm = 1'b1;
					s_next.elapsed = '0;
					if (s_reg.bit_cnt == cecr_pkg::EOM_BIT)
					begin
						// store byte and eom in order
						wr_nx = s_reg.wr_ptr + (AW + 1)'(1);
						if (wr_nx == {~s_reg.rd_ptr[AW], s_reg.rd_ptr[AW-1:0]} + (AW + 1)'(1))
							s_next.err.overflow = 1'b1;
						else
						begin
							s_next.mem[s_reg.wr_ptr[AW-1:0]] = '{data: s_reg.shreg, eom: s_reg.eom};
							s_next.wr_ptr                    = wr_nx;
						end
						s_next.state = cecr_pkg::ST_ACK_HOLD;
						s_next.tmr   = cecr_pkg::SAMPLE_T;
						s_next.oe    = ACK_EN_I;
					end
					else
					begin
						s_next.state   = cecr_pkg::ST_BIT_SAMPLE;
						s_next.tmr     = cecr_pkg::SAMPLE_T;
						s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
					end
				end
				else if (tmr_hit && (s_reg.state == cecr_pkg::ST_BIT_SAMPLE))
				begin
					if (s_reg.bit_cnt == cecr_pkg::EOM_BIT)
						s_next.eom = line;
					else
						s_next.shreg = {s_reg.shreg[6:0], line};
					s_next.state = cecr_pkg::ST_BIT_WAIT;
					s_next.tmr   = cecr_pkg::BIT_TO;
				end
				else if (tmr_hit)
				begin
					s_next.err.data_tm = 1'b1;
					s_next.state       = cecr_pkg::ST_SFT;
					s_next.tmr         = cecr_pkg::SFT_T;
				end
			end
			cecr_pkg::ST_ACK_HOLD:
			begin
				// own release makes a rise here, so edges are ignored
				if (tmr_hit)
				begin
					s_next.oe = 1'b0;
					if (s_reg.eom)
					begin
						s_next.state = cecr_pkg::ST_SFT;
						s_next.tmr   = cecr_pkg::SFT_T;
					end
					else
					begin
						s_next.state = cecr_pkg::ST_ACK_GAP;
						s_next.tmr   = cecr_pkg::ACK_GAP_T;
					end
				end
			end
			cecr_pkg::ST_ACK_GAP:
			begin
				if (fall)
				begin
					s_next.state   = cecr_pkg::ST_BIT_SAMPLE;
					s_next.tmr     = cecr_pkg::SAMPLE_T;
					s_next.bit_cnt = '0;
					s_next.elapsed = '0;
				end
				else if (tmr_hit)
				begin
					s_next.state = cecr_pkg::ST_SFT;
					s_next.tmr   = cecr_pkg::SFT_T;
				end
			end
			cecr_pkg::ST_ERR_LOW:
			begin
				if (tmr_hit)
				begin
					s_next.oe    = 1'b0;
					s_next.state = cecr_pkg::ST_SFT;
					s_next.tmr   = cecr_pkg::SFT_T;
				end
			end
			default:
			begin
				s_next.state = cecr_pkg::ST_IDLE;
				s_next.oe    = 1'b0;
			end
		endcase

		if (RB_RD_I && s_reg.nonempty)
		begin
			s_next.rd_data = s_reg.mem[s_reg.rd_ptr[AW-1:0]];
			s_next.rd_ptr  = s_reg.rd_ptr + (AW + 1)'(1);
		end
		s_next.nonempty = (s_next.wr_ptr != s_next.rd_ptr);
		s_next.idle     = (s_next.state == cecr_pkg::ST_IDLE);
	end

	// all state in one register
	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_reg       <= '0;
			s_reg.state <= cecr_pkg::ST_IDLE;
			s_reg.idle  <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// ==========================================
	// outputs; line data is always low, only the enable toggles
	assign CEC_LINE_O               = 1'b0;
	assign CEC_LINE_OE_O            = s_reg.oe;
	assign RB_DATA_O                = s_reg.rd_data.data;
	assign RB_EOM_O                 = s_reg.rd_data.eom;
	assign RB_NONEMPTY_O            = s_reg.nonempty;
	assign LINE_IDLE_O              = s_reg.idle;
	assign START_BIT_TIMING_ERROR_O = s_reg.err.start_tm;
	assign DATA_BIT_TIMING_ERROR_O  = s_reg.err.data_tm;
	assign RECEIVE_HANDLING_ERROR_O = s_reg.err.handling;
	assign RB_OVERFLOW_O            = s_reg.err.overflow;
endmodule // cecr_rx
`default_nettype wire

/* File: verilog/cecr_pkg.sv */
// cecr_pkg: constants, states and carriers for the single-wire bit receiver.
// Assumes a 250 MHz system clock and a 10 us timer tick made from it.
`default_nettype none
package cecr_pkg;
	// ==========================================
	// clock and tick
	localparam int CLK_NS   = 4;
	localparam int TICK_NS  = 10000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int DIV_W    = 12;
	localparam int T_W      = 11;

	// ==========================================
	// times in microseconds, as given
	localparam int START_TO_US  = 6000;
	localparam int SAMPLE_US    = 1050;
	localparam int BIT_TO_US    = 3600;
	localparam int ACK_GAP_US   = 1500;
	localparam int SFT_US       = 12000;
	localparam int ERR_LOW_US   = 3600;
	// acceptance windows, plain defaults
	localparam int ST_A_MIN_US  = 3500;
	localparam int ST_A_MAX_US  = 3900;
	localparam int ST_B_MIN_US  = 4300;
	localparam int ST_B_MAX_US  = 4700;
	localparam int ONE_MIN_US   = 400;
	localparam int ONE_MAX_US   = 800;
	localparam int ZERO_MIN_US  = 1300;
	localparam int ZERO_MAX_US  = 1700;
	localparam int BIT_B_MIN_US = 2050;
	localparam int BIT_B_MAX_US = 2750;

	// ==========================================
	// same times in ticks: least times round up, longest round down
	localparam logic [T_W-1:0] START_TO  = T_W'(START_TO_US * 1000 / TICK_NS);
	localparam logic [T_W-1:0] SAMPLE_T  = T_W'((SAMPLE_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] BIT_TO    = T_W'(BIT_TO_US * 1000 / TICK_NS);
	localparam logic [T_W-1:0] ACK_GAP_T = T_W'(ACK_GAP_US * 1000 / TICK_NS);
	localparam logic [T_W-1:0] SFT_T     = T_W'((SFT_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] ERR_LOW_T = T_W'((ERR_LOW_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] ST_A_MIN  = T_W'((ST_A_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] ST_A_MAX  = T_W'(ST_A_MAX_US * 1000 / TICK_NS);
	localparam logic [T_W-1:0] ST_B_MIN  = T_W'((ST_B_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] ST_B_MAX  = T_W'(ST_B_MAX_US * 1000 / TICK_NS);
	localparam logic [T_W-1:0] ONE_MIN   = T_W'((ONE_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] ONE_MAX   = T_W'(ONE_MAX_US * 1000 / TICK_NS);
	localparam logic [T_W-1:0] ZERO_MIN  = T_W'((ZERO_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] ZERO_MAX  = T_W'(ZERO_MAX_US * 1000 / TICK_NS);
	localparam logic [T_W-1:0] BIT_B_MIN = T_W'((BIT_B_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [T_W-1:0] BIT_B_MAX = T_W'(BIT_B_MAX_US * 1000 / TICK_NS);

	// ==========================================
	// byte framing and ring buffer
	localparam logic [3:0] EOM_BIT  = 4'h8;
	localparam int         RB_AW    = 4;
	localparam int         RB_DEPTH = 16;

	typedef enum logic [3:0] {
		ST_IDLE, ST_START_LOW, ST_START_HIGH, ST_BIT_SAMPLE, ST_BIT_WAIT,
		ST_ACK_HOLD, ST_ACK_GAP, ST_ERR_LOW, ST_SFT
	} cecr_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       eom;
	} cecr_entry_t;

	typedef struct packed {
		logic start_tm;
		logic data_tm;
		logic handling;
		logic overflow;
	} cecr_err_t;
endpackage
`default_nettype wire

/* File: verilog/cecr_timebase.sv */
// cecr_timebase: line synchroniser, edge detect and 10 us tick divider.
// Assumes the line pin is asynchronous and the reset is already synchronised.
`timescale 1ns/100ps
`default_nettype none
module cecr_timebase
#(
	// clocks per timer tick; a bench may shorten it to keep runs brief
	parameter int TICK_CYC = cecr_pkg::TICK_CYC
)
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// raw line
	input  wire logic line_i,
	// conditioned outputs
	output logic      line_o,
	output logic      fall_o,
	output logic      rise_o,
	output logic      tick_o
);
	typedef struct packed {
		logic                       meta;
		logic                       sync;
		logic                       prev;
		logic [cecr_pkg::DIV_W-1:0] div;
		logic                       tick;
	} cecr_tb_t;

	cecr_tb_t s_reg;
	cecr_tb_t s_next;

	// ==========================================
	// next state; edges look only at the second and third stages
	always_comb
	begin
		s_next      = s_reg;
		s_next.meta = line_i;
		s_next.sync = s_reg.meta;
		s_next.prev = s_reg.sync;
		s_next.tick = (s_reg.div == cecr_pkg::DIV_W'(TICK_CYC - 1));
		if (s_next.tick)
			s_next.div = '0;
		else
			s_next.div = s_reg.div + cecr_pkg::DIV_W'(1);
	end

	// idle line is high, so reset to high avoids a false fall
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_reg <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, div: '0, tick: 1'b0};
		else
			s_reg <= s_next;
	end

	assign line_o = s_reg.sync;
	assign fall_o = s_reg.prev & ~s_reg.sync;
	assign rise_o = ~s_reg.prev & s_reg.sync;
	assign tick_o = s_reg.tick;
endmodule // cecr_timebase
`default_nettype wire

/* File: tb/cecr_rx_chk.sv */
// cecr_rx_chk: port-level assertions for the bit receiver.
// Assumes it is bound onto cecr_rx; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module cecr_rx_chk
#(
	// must match the bound receiver's tick length
	parameter int TICK_CYC = cecr_pkg::TICK_CYC
)
(
	// clock and reset
	input wire logic       MCLK_I,
	input wire logic       RESETN_I,
	// line and control
	input wire logic       CEC_LINE_I,
	input wire logic       CEC_LINE_O,
	input wire logic       CEC_LINE_OE_O,
	input wire logic       ACK_EN_I,
	input wire logic       ERR_CLR_I,
	// buffer and status
	input wire logic       RB_RD_I,
	input wire logic [7:0] RB_DATA_O,
	input wire logic       RB_EOM_O,
	input wire logic       RB_NONEMPTY_O,
	input wire logic       LINE_IDLE_O,
	input wire logic       START_BIT_TIMING_ERROR_O,
	input wire logic       DATA_BIT_TIMING_ERROR_O,
	input wire logic       RECEIVE_HANDLING_ERROR_O,
	input wire logic       RB_OVERFLOW_O
);
	localparam int TK = TICK_CYC;
	int            oe_cnt;
	int            quiet_cnt;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);
	// ==========
	// drive length and quiet time of the pin
	always_ff @(posedge MCLK_I or negedge RESETN_I)
		if (!RESETN_I)
		begin
			oe_cnt    <= 0;
			quiet_cnt <= 0;
		end
		else
		begin
			oe_cnt    <= CEC_LINE_OE_O ? oe_cnt + 1 : 0;
			quiet_cnt <= CEC_LINE_I ? quiet_cnt + 1 : 0;
		end
	chk_line_od: assert property (CEC_LINE_O == 1'b0)
		else $error("line data not zero");
	chk_drive_cause: assert property ($rose(CEC_LINE_OE_O) |-> !$past(CEC_LINE_I, 3))
		else $error("drive without a fall");
	chk_ack_min: assert property ($fell(CEC_LINE_OE_O) |-> oe_cnt >= 104 * TK)
		else $error("drive released early");
	chk_drive_max: assert property (CEC_LINE_OE_O |-> oe_cnt <= 361 * TK)
		else $error("drive held too long");
	chk_idle_quiet: assert property (LINE_IDLE_O |-> !CEC_LINE_OE_O)
		else $error("drive while idle");
	chk_idle_leave: assert property (LINE_IDLE_O && $fell(CEC_LINE_I) |-> ##[1:6] !LINE_IDLE_O)
		else $error("fall did not leave idle");
	chk_idle_sft: assert property ($rose(LINE_IDLE_O) |-> quiet_cnt >= 1199 * TK
		|| START_BIT_TIMING_ERROR_O || RECEIVE_HANDLING_ERROR_O)
		else $error("idle before free time");
	chk_start_sticky: assert property (START_BIT_TIMING_ERROR_O && !ERR_CLR_I |=> START_BIT_TIMING_ERROR_O)
		else $error("start error lost");
	chk_data_sticky: assert property (DATA_BIT_TIMING_ERROR_O && !ERR_CLR_I |=> DATA_BIT_TIMING_ERROR_O)
		else $error("data error lost");
	chk_hand_sticky: assert property (RECEIVE_HANDLING_ERROR_O && !ERR_CLR_I |=> RECEIVE_HANDLING_ERROR_O)
		else $error("handling error lost");
	chk_pop_empty: assert property (!RB_NONEMPTY_O && RB_RD_I |=> $stable(RB_DATA_O) && $stable(RB_EOM_O))
		else $error("pop from empty changed data");
	cov_ack: cover property ($fell(CEC_LINE_OE_O));
	cov_idle: cover property ($rose(LINE_IDLE_O));
	cov_hand: cover property ($rose(RECEIVE_HANDLING_ERROR_O));
endmodule // cecr_rx_chk
bind cecr_rx cecr_rx_chk #(.TICK_CYC(TICK_CYC)) cecr_rx_chk_inst (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
	.CEC_LINE_I(CEC_LINE_I),
	.CEC_LINE_O(CEC_LINE_O), .CEC_LINE_OE_O(CEC_LINE_OE_O), .ACK_EN_I(ACK_EN_I), .ERR_CLR_I(ERR_CLR_I),
	.RB_RD_I(RB_RD_I), .RB_DATA_O(RB_DATA_O), .RB_EOM_O(RB_EOM_O), .RB_NONEMPTY_O(RB_NONEMPTY_O),
	.LINE_IDLE_O(LINE_IDLE_O), .START_BIT_TIMING_ERROR_O(START_BIT_TIMING_ERROR_O),
	.DATA_BIT_TIMING_ERROR_O(DATA_BIT_TIMING_ERROR_O),
	.RECEIVE_HANDLING_ERROR_O(RECEIVE_HANDLING_ERROR_O), .RB_OVERFLOW_O(RB_OVERFLOW_O));
`default_nettype wire

/* File: tb/cecr_far_end.sv */
// cecr_far_end: initiator on the shared line, timed in 10 us ticks.
// Assumes the bench forms the wired-AND with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module cecr_far_end
#(
	// clocks per tick, same as the receiver's
	parameter int TICK_CYC = cecr_pkg::TICK_CYC
)
(
	// clock
	input  wire logic clk_i,
	// high pulls the line low
	output logic      pull_low_o
);
	initial pull_low_o = 1'b0;
	// ==========
	// timing helpers, entered just at a rising edge
	task automatic wait_ticks(input int n);
		repeat (n * TICK_CYC) @(posedge clk_i);
	endtask
	// released pin floats to the pull-up, never holds a stale level
	task automatic pulse(input int lo, input int tot);
		#1 pull_low_o = 1'b1;
		wait_ticks(lo);
		#1 pull_low_o = 1'b0;
		wait_ticks(tot - lo);
	endtask
	task automatic send_byte(input logic [7:0] d, input logic eom);
		for (int i = 7; i >= 0; i--)
			pulse(d[i] ? 60 : 150, 240);
		pulse(eom ? 60 : 150, 240);
	endtask
endmodule // cecr_far_end
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: frames and faulty bits against the receiver, checked by a queue model.
// Assumes the design package is compiled first; the line has a pull-up.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic       mclk, resetn, far_low, oe, ack_en, err_clr, rb_rd;
	logic [7:0] rb_data;
	logic       rb_eom, nonempty, idle, st_e, d_e, h_e, ovf, unused_o;
	logic [15:0] lfsr_q;
	logic [8:0]  exp_q[$];
	logic [8:0]  last;
	int          failures, samples_checked;
	int          cs[4][5] = '{'{370, 450, 100, 240, 2}, '{370, 450, 60, 150, 1},
		'{370, 450, 60, 300, 2}, '{300, 450, 60, 240, 4}};
	wire logic  cec_line;
	// short tick keeps the whole run near 72k clocks; all times stay in ticks
	localparam int TB_TICK = 4;
	// wired-AND of both pulls with pull-up
	assign cec_line = ~(far_low | oe);
	cecr_rx #(.TICK_CYC(TB_TICK)) cecr_rx_inst (.MCLK_I(mclk), .RESETN_I(resetn), .CEC_LINE_I(cec_line),
		.CEC_LINE_O(unused_o),
		.CEC_LINE_OE_O(oe), .ACK_EN_I(ack_en), .ERR_CLR_I(err_clr), .RB_RD_I(rb_rd), .RB_DATA_O(rb_data),
		.RB_EOM_O(rb_eom), .RB_NONEMPTY_O(nonempty), .LINE_IDLE_O(idle), .START_BIT_TIMING_ERROR_O(st_e),
		.DATA_BIT_TIMING_ERROR_O(d_e), .RECEIVE_HANDLING_ERROR_O(h_e), .RB_OVERFLOW_O(ovf));
	cecr_far_end #(.TICK_CYC(TB_TICK)) cecr_far_end_inst (.clk_i(mclk), .pull_low_o(far_low));
	// ==========
	// helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ticks(input int n);
		cecr_far_end_inst.wait_ticks(n);
	endtask
	task automatic strobe(input logic clr);
		@(posedge mclk);
		#1 err_clr = clr;
		rb_rd = !clr;
		@(posedge mclk);
		#1 err_clr = 1'b0;
		rb_rd = 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========
	// clock and watchdog
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		// tests need about 72k clocks; give up at 100k clocks of 4 ns
		#400000;
		failures++;
		test_done();
	end
	// ==========
	// main sequence
	initial
	begin
		resetn = 1'b0;
		ack_en = 1'b0;
		err_clr = 1'b0;
		rb_rd = 1'b0;
		lfsr_q = 16'hEA6B;
		repeat (6) @(posedge mclk);
		#1 resetn = 1'b1;
		repeat (10) @(posedge mclk);
		// two-byte frame, random data and acknowledge choice
		cecr_far_end_inst.pulse(370, 450);
		for (int b = 0; b < 2; b++)
		begin
			lfsr_q = lfsr_next(lfsr_q);
			#1 ack_en = lfsr_q[8];
			exp_q.push_back({lfsr_q[7:0], b == 1});
			cecr_far_end_inst.send_byte(lfsr_q[7:0], b == 1);
			fork
				cecr_far_end_inst.pulse(60, 240);
				begin
					ticks(80);
					check(oe, ack_en);
					check(unused_o, 1'b0);
				end
			join
		end
		ticks(900);
		check(idle, 1'b0);
		ticks(300);
		check({idle, st_e, d_e, h_e}, 9'h008);
		while (exp_q.size() > 0)
		begin
			check(nonempty, 1'b1);
			strobe(1'b0);
			last = exp_q.pop_front();
			check({rb_data, rb_eom}, last);
		end
		check(nonempty, 1'b0);
		strobe(1'b0);
		check({rb_data, rb_eom}, last);
		check(ovf, 1'b0);
		$display("test frame done");
		// faulty bit and start timings, flags {start, data, handling}
		foreach (cs[i])
		begin
			fork
				begin
					cecr_far_end_inst.pulse(cs[i][0], cs[i][1]);
					cecr_far_end_inst.pulse(cs[i][2], cs[i][3]);
					cecr_far_end_inst.pulse(20, 240);
				end
				begin
					ticks(cs[i][1] + cs[i][3] + 30);
					check({st_e, d_e, h_e}, 9'(cs[i][4]));
					check(oe, cs[i][4] == 1);
				end
			join
			ticks(1800);
			check(idle, 1'b1);
			strobe(1'b1);
			check({st_e, d_e, h_e}, 9'h000);
			$display("test fault %0d done", i);
		end
		// start bit with no following edge
		fork
			cecr_far_end_inst.pulse(700, 700);
			begin
				ticks(650);
				check({st_e, d_e, h_e}, 9'h001);
			end
		join
		ticks(10);
		check(idle, 1'b1);
		strobe(1'b1);
		$display("test timeout done");
		test_done();
	end
endmodule // testbench
`default_nettype wire
